// ==== hw/clock_prescaler_tick_timer_consts.svh ====
/*
  Offsets, field positions, reset values and cycle counts of the clock
  prescaler and tick timer. Assumes an 8-bit register port with a 2-bit
  word address.
*/
`ifndef CLOCK_PRESCALER_TICK_TIMER_CONSTS_SVH
`define CLOCK_PRESCALER_TICK_TIMER_CONSTS_SVH

// Register word addresses
`define CCS_ADDR_CTRL 2'h0
`define CCS_ADDR_IRQ_STATUS 2'h1
`define CCS_ADDR_IRQ_CLEAR 2'h2
`define CCS_ADDR_IRQ_ENABLE 2'h3

// Control register field positions
`define CCS_BIT_CLK_OUT 7
`define CCS_BIT_DIV_HI 6
`define CCS_BIT_DIV_LO 5
`define CCS_BIT_SLOW 4
`define CCS_BIT_TB_HI 3
`define CCS_BIT_TB_LO 2
`define CCS_BIT_TICK_IE 1
`define CCS_BIT_TICK_FLAG 0

// Reset value of the control register
`define CCS_CTRL_RESET 8'h00

// Interrupt status bit positions
`define CCS_IRQ_BIT_TICK 0
`define CCS_IRQ_BIT_WAKE 1
`define CCS_IRQ_BITS 2

// Time-base periods in oscillator cycles
`define CCS_TB_PERIOD_0 16000
`define CCS_TB_PERIOD_1 32000
`define CCS_TB_PERIOD_2 80000
`define CCS_TB_PERIOD_3 200000
`define CCS_TB_CNT_W 18

// Slow divider counter width, enough for divide by 16
`define CCS_DIV_CNT_W 4

`endif

// ==== hw/clock_prescaler_tick_timer_pkg.sv ====
/*
  Types of the clock prescaler and tick timer.
  Assumes the constants header is compiled alongside.
*/
package clock_prescaler_tick_timer_pkg;

    // Power state of the block as seen by the clock controller
    typedef enum logic [1:0] {
        ST_RUN,
        ST_ACTIVE_HALT,
        ST_FULL_HALT
    } power_state_t;

    // Two-bit select codes
    typedef logic [1:0] sel2_t;

endpackage : clock_prescaler_tick_timer_pkg

// ==== hw/tick_link_if.sv ====
/*
  Interface between the control logic and the time-base counter.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps

interface tick_link_if;
    import clock_prescaler_tick_timer_pkg::*;

    sel2_t time_base_select; // Requested time-base code
    logic run; // Counter advances while high
    logic tick; // One-cycle pulse on each period wrap

    modport ctrl (output time_base_select, output run, input tick);
    modport timer (input time_base_select, input run, output tick);
endinterface : tick_link_if

// ==== hw/tick_time_base.sv ====
/*
  Time-base counter: counts oscillator cycles, wraps at the selected period
  and pulses tick on each wrap. A new period select is adopted only at a wrap.
  Assumes the control end holds run low in full halt.
*/
`timescale 1ns/1ps
`include "clock_prescaler_tick_timer_consts.svh"

module tick_time_base #(
    parameter int unsigned PERIOD_0 = `CCS_TB_PERIOD_0,
    parameter int unsigned PERIOD_1 = `CCS_TB_PERIOD_1,
    parameter int unsigned PERIOD_2 = `CCS_TB_PERIOD_2,
    parameter int unsigned PERIOD_3 = `CCS_TB_PERIOD_3
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    tick_link_if.timer link
);
    import clock_prescaler_tick_timer_pkg::*;

    logic [`CCS_TB_CNT_W-1:0] cnt_q, cnt_d; // Cycles into current period
    sel2_t sel_q, sel_d; // Select in force for current period
    logic tick_q, tick_d; // Wrap pulse

    // Last count of a period for a select code
    function automatic logic [`CCS_TB_CNT_W-1:0] last_count(input sel2_t sel);
        case (sel)
            2'h0: last_count = `CCS_TB_CNT_W'(PERIOD_0 - 1);
            2'h1: last_count = `CCS_TB_CNT_W'(PERIOD_1 - 1);
            2'h2: last_count = `CCS_TB_CNT_W'(PERIOD_2 - 1);
            default: last_count = `CCS_TB_CNT_W'(PERIOD_3 - 1);
        endcase
    endfunction : last_count

    // Next count, select and pulse
    always_comb begin
        cnt_d = cnt_q;
        sel_d = sel_q;
        tick_d = 1'b0;
        if (link.run) begin
            if (cnt_q >= last_count(sel_q)) begin
                cnt_d = '0;
                tick_d = 1'b1;
                // Adopting only here keeps ticks phase aligned
                sel_d = link.time_base_select;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    // Register stage, frozen by clock enable
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= '0;
            sel_q <= 2'h0;
            tick_q <= 1'b0;
        end else if (i_clk_en) begin
            cnt_q <= cnt_d;
            sel_q <= sel_d;
            tick_q <= tick_d;
        end
    end

    assign link.tick = tick_q;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    AST_TB_SEL_AT_WRAP: assert property (
        (sel_q != $past(sel_q)) |-> tick_q)
        else $error("Time-base select changed away from a wrap");

    AST_TB_WRAP_COUNT: assert property (
        (i_clk_en && link.run && cnt_q == last_count(sel_q)) |=> (tick_q && cnt_q == 0))
        else $error("Counter did not wrap at selected period");

    AST_TB_FROZEN: assert property (
        (i_clk_en && !link.run) |=> ($stable(cnt_q) && !tick_q))
        else $error("Counter moved while stopped");
endmodule : tick_time_base

// ==== hw/clock_prescaler_tick_timer.sv ====
/*
  Clock control and status register with slow-mode prescaler, clock-out
  select, time-base tick timer, halt state tracking and interrupt registers.
  Assumes a single oscillator-derived clock, a synchronous register port and
  a processor that pulses i_halt_req when it runs its halt instruction.
*/
// What this block does
// - Bit 7 routes oscillator clock to pin
// - Clock-out inactive during active halt
// - Slow divider codes give divide 2/4/8/16
// - Divider ignored unless slow mode selected
// - Slow select chooses oscillator or divided clock
// - Time-base codes give 16k/32k/80k/200k periods
// - New time base applies after current period
// - Bit 1 is software tick interrupt enable
// - Halt with enable set enters active halt
// - Tick interrupt wakes from active halt
// - Hardware sets tick flag each period
// - Register read clears flag; writes cannot
// - Control register resets to all zero
// - Tick request needs enable and unmasked processor
// - Full halt freezes counter and registers
`timescale 1ns/1ps
`include "clock_prescaler_tick_timer_consts.svh"

module clock_prescaler_tick_timer #(
    parameter int unsigned PERIOD_0 = `CCS_TB_PERIOD_0,
    parameter int unsigned PERIOD_1 = `CCS_TB_PERIOD_1,
    parameter int unsigned PERIOD_2 = `CCS_TB_PERIOD_2,
    parameter int unsigned PERIOD_3 = `CCS_TB_PERIOD_3
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_halt_req,
    input wire logic i_wake,
    input wire logic i_int_mask,
    output logic o_core_clk_en,
    output logic o_clock_out_select,
    output logic o_tick_req,
    output logic o_irq,
    output clock_prescaler_tick_timer_pkg::power_state_t o_power_state
);
    import clock_prescaler_tick_timer_pkg::*;

    tick_link_if link (); // Control to counter link

    // Control register fields
    logic clock_out_enable_q, clock_out_enable_d;
    sel2_t slow_divider_select_q, slow_divider_select_d;
    logic slow_mode_select_q, slow_mode_select_d;
    sel2_t time_base_select_q, time_base_select_d;
    logic tick_interrupt_enable_q, tick_interrupt_enable_d;
    logic tick_flag_q, tick_flag_d;

    // Interrupt status and enable, one bit per event
    logic [`CCS_IRQ_BITS-1:0] irq_status_q, irq_status_d;
    logic [`CCS_IRQ_BITS-1:0] irq_enable_q, irq_enable_d;

    // Power state
    power_state_t state_q, state_d;
    logic wake_event; // Leaving either halt this cycle

    // Prescaler and registered outputs
    logic [`CCS_DIV_CNT_W-1:0] div_cnt_q, div_cnt_d;
    logic core_clk_en_q, core_clk_en_d;
    logic clock_out_select_q, clock_out_select_d;
    logic tick_req_q, tick_req_d;
    logic irq_q, irq_d;
    logic [7:0] rdata_q, rdata_d;

    logic frozen; // Registers held in full halt
    logic wr_ctrl, rd_ctrl; // Accesses to the control register

    // Low bits of the divider that must all be set to pulse the clock enable
    function automatic logic [`CCS_DIV_CNT_W-1:0] div_mask(input sel2_t sel);
        case (sel)
            2'h0: div_mask = 4'h1;
            2'h1: div_mask = 4'h3;
            2'h2: div_mask = 4'h7;
            default: div_mask = 4'hf;
        endcase
    endfunction : div_mask

    // Assembled control register image
    function automatic logic [7:0] ctrl_image(input logic co, input sel2_t dv, input logic sm,
                                              input sel2_t tb, input logic ie, input logic fl);
        ctrl_image = {co, dv, sm, tb, ie, fl};
    endfunction : ctrl_image

    assign frozen = (state_q == ST_FULL_HALT);
    assign wr_ctrl = i_wr && !frozen && (i_addr == `CCS_ADDR_CTRL);
    assign rd_ctrl = i_rd && !frozen && (i_addr == `CCS_ADDR_CTRL);

    // Counter keeps running in active halt, stops only in full halt
    assign link.run = !frozen;
    assign link.time_base_select = time_base_select_q;

    tick_time_base #(
        .PERIOD_0(PERIOD_0),
        .PERIOD_1(PERIOD_1),
        .PERIOD_2(PERIOD_2),
        .PERIOD_3(PERIOD_3)
    ) u_time_base (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_clk_en(i_clk_en),
        .link(link)
    );

    // Next values of the register file
    always_comb begin
        clock_out_enable_d = clock_out_enable_q;
        slow_divider_select_d = slow_divider_select_q;
        slow_mode_select_d = slow_mode_select_q;
        time_base_select_d = time_base_select_q;
        tick_interrupt_enable_d = tick_interrupt_enable_q;
        tick_flag_d = tick_flag_q;
        irq_status_d = irq_status_q;
        irq_enable_d = irq_enable_q;
        rdata_d = 8'h00;
        if (wr_ctrl) begin
            clock_out_enable_d = i_wdata[`CCS_BIT_CLK_OUT];
            slow_divider_select_d = i_wdata[`CCS_BIT_DIV_HI:`CCS_BIT_DIV_LO];
            slow_mode_select_d = i_wdata[`CCS_BIT_SLOW];
            time_base_select_d = i_wdata[`CCS_BIT_TB_HI:`CCS_BIT_TB_LO];
            tick_interrupt_enable_d = i_wdata[`CCS_BIT_TICK_IE];
            // Flag bit of the write data is dropped on purpose
        end
        if (i_wr && !frozen && i_addr == `CCS_ADDR_IRQ_ENABLE) begin
            irq_enable_d = i_wdata[`CCS_IRQ_BITS-1:0];
        end
        if (i_wr && !frozen && i_addr == `CCS_ADDR_IRQ_CLEAR) begin
            irq_status_d = irq_status_q & ~i_wdata[`CCS_IRQ_BITS-1:0];
        end
        // Read clears the flag, a tick in the same cycle still lands
        if (rd_ctrl) begin
            tick_flag_d = 1'b0;
        end
        if (link.tick) begin
            tick_flag_d = 1'b1;
            irq_status_d[`CCS_IRQ_BIT_TICK] = 1'b1;
        end
        if (wake_event) begin
            irq_status_d[`CCS_IRQ_BIT_WAKE] = 1'b1;
        end
        // Read data, unmapped or write-only words read zero
        if (i_rd && !frozen) begin
            case (i_addr)
                `CCS_ADDR_CTRL: rdata_d = ctrl_image(clock_out_enable_q, slow_divider_select_q,
                    slow_mode_select_q, time_base_select_q, tick_interrupt_enable_q, tick_flag_q);
                `CCS_ADDR_IRQ_STATUS: rdata_d = {6'h00, irq_status_q};
                `CCS_ADDR_IRQ_ENABLE: rdata_d = {6'h00, irq_enable_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // Register file storage, all zero after reset
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            {clock_out_enable_q, slow_divider_select_q, slow_mode_select_q,
             time_base_select_q, tick_interrupt_enable_q, tick_flag_q} <= `CCS_CTRL_RESET;
            irq_status_q <= '0;
            irq_enable_q <= '0;
            rdata_q <= 8'h00;
        end else if (i_clk_en) begin
            clock_out_enable_q <= clock_out_enable_d;
            slow_divider_select_q <= slow_divider_select_d;
            slow_mode_select_q <= slow_mode_select_d;
            time_base_select_q <= time_base_select_d;
            tick_interrupt_enable_q <= tick_interrupt_enable_d;
            tick_flag_q <= tick_flag_d;
            irq_status_q <= irq_status_d;
            irq_enable_q <= irq_enable_d;
            rdata_q <= rdata_d;
        end
    end

    // Power state transitions
    always_comb begin
        state_d = state_q;
        wake_event = 1'b0;
        case (state_q)
            ST_RUN: begin
                if (i_halt_req) begin
                    // Enabled tick interrupt selects the lighter halt
                    state_d = tick_interrupt_enable_q ? ST_ACTIVE_HALT : ST_FULL_HALT;
                end
            end
            ST_ACTIVE_HALT: begin
                if ((link.tick && tick_interrupt_enable_q) || i_wake) begin
                    state_d = ST_RUN;
                    wake_event = 1'b1;
                end
            end
            ST_FULL_HALT: begin
                // Tick cannot fire here, only an external wake source
                if (i_wake) begin
                    state_d = ST_RUN;
                    wake_event = 1'b1;
                end
            end
            default: state_d = ST_RUN;
        endcase
    end

    // Power state register
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= ST_RUN;
        end else if (i_clk_en) begin
            state_q <= state_d;
        end
    end

    // Prescaler and output stage
    always_comb begin
        div_cnt_d = div_cnt_q + 1'b1;
        core_clk_en_d = 1'b0;
        if (state_d == ST_RUN) begin
            if (!slow_mode_select_q) begin
                core_clk_en_d = 1'b1;
            end else begin
                // Divider only matters here, ignored in normal mode
                core_clk_en_d = ((div_cnt_d & div_mask(slow_divider_select_q)) ==
                                 div_mask(slow_divider_select_q));
            end
        end
        // Pad function taken back in active halt to save power
        clock_out_select_d = clock_out_enable_q && (state_d != ST_ACTIVE_HALT);
        tick_req_d = tick_flag_d && tick_interrupt_enable_d && !i_int_mask;
        irq_d = |(irq_status_d & irq_enable_d);
    end

    // Output registers
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_cnt_q <= '0;
            core_clk_en_q <= 1'b0;
            clock_out_select_q <= 1'b0;
            tick_req_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (i_clk_en) begin
            div_cnt_q <= div_cnt_d;
            core_clk_en_q <= core_clk_en_d;
            clock_out_select_q <= clock_out_select_d;
            tick_req_q <= tick_req_d;
            irq_q <= irq_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_core_clk_en = core_clk_en_q;
    assign o_clock_out_select = clock_out_select_q;
    assign o_tick_req = tick_req_q;
    assign o_irq = irq_q;
    assign o_power_state = state_q;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    AST_CLKOUT_ROUTE: assert property (
        (i_clk_en && clock_out_enable_q && state_d == ST_RUN) |=> o_clock_out_select)
        else $error("Clock-out not selected while enabled");

    AST_CLKOUT_ACTIVE_HALT: assert property (
        (state_q == ST_ACTIVE_HALT && $past(state_q) == ST_ACTIVE_HALT) |-> !o_clock_out_select)
        else $error("Clock-out active in active halt");

    AST_FAST_CLOCK: assert property (
        (i_clk_en && !slow_mode_select_q && state_d == ST_RUN) |=> o_core_clk_en)
        else $error("Core clock enable missing in normal mode");

    // The last normal-mode pulse may meet the first slow pulse, so only pulses made in slow mode count
    AST_SLOW_NO_BACK_TO_BACK: assert property (
        (i_clk_en && slow_mode_select_q && $past(slow_mode_select_q) && o_core_clk_en) |=> !o_core_clk_en)
        else $error("Slow core clock enable two cycles running");

    AST_DIV16_SPACING: assert property (
        (i_clk_en && slow_mode_select_q && slow_divider_select_q == 2'h3 && o_core_clk_en
         && $past(slow_mode_select_q) && $past(slow_divider_select_q) == 2'h3)
        ##1 (i_clk_en && slow_mode_select_q && slow_divider_select_q == 2'h3 && state_q == ST_RUN)[*8]
        |-> !o_core_clk_en)
        else $error("Divide by 16 pulsed too early");

    AST_TICK_SETS_FLAG: assert property (
        (i_clk_en && link.tick) |=> tick_flag_q)
        else $error("Tick did not set flag");

    AST_READ_CLEARS_FLAG: assert property (
        (i_clk_en && rd_ctrl && !link.tick) |=> !tick_flag_q)
        else $error("Read did not clear flag");

    AST_WRITE_KEEPS_FLAG: assert property (
        (i_clk_en && wr_ctrl && !link.tick) |=> (tick_flag_q == $past(tick_flag_q)))
        else $error("Write changed flag");

    AST_ACTIVE_HALT_ENTRY: assert property (
        (i_clk_en && state_q == ST_RUN && i_halt_req && tick_interrupt_enable_q)
        |=> o_power_state == ST_ACTIVE_HALT)
        else $error("Halt with enable did not enter active halt");

    AST_TICK_WAKES: assert property (
        (i_clk_en && state_q == ST_ACTIVE_HALT && link.tick && tick_interrupt_enable_q)
        |=> o_power_state == ST_RUN)
        else $error("Tick did not wake from active halt");

    AST_TICK_REQUEST: assert property (
        (i_clk_en && tick_flag_d && tick_interrupt_enable_d && !i_int_mask) |=> o_tick_req)
        else $error("Tick request not raised");

    AST_FULL_HALT_FREEZE: assert property (
        (i_clk_en && frozen && !link.tick)
        |=> $stable(ctrl_image(clock_out_enable_q, slow_divider_select_q, slow_mode_select_q,
                                time_base_select_q, tick_interrupt_enable_q, tick_flag_q)))
        else $error("Register changed in full halt");
endmodule : clock_prescaler_tick_timer

// ==== verification/clock_prescaler_tick_timer_tb_top.sv ====
/*
  Self-checking bench for the clock prescaler and tick timer: register port,
  time-base periods, read-clear flag, interrupts, slow mode, clock-out, halt.
  Assumes the design package, constants header and tick_link_if are compiled
  first; periods are shrunk to 8/12/16/20 cycles to keep the run short.
*/
`timescale 1ns/1ps
`include "clock_prescaler_tick_timer_consts.svh"

module clock_prescaler_tick_timer_tb_top;
    import clock_prescaler_tick_timer_pkg::*;

    logic i_core_clk; // 100 MHz oscillator clock
    logic i_rst_b; // Active-low reset
    logic i_clk_en; // Held high: freezing is not exercised here
    logic [1:0] i_addr;
    logic [7:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [7:0] o_rdata;
    logic i_halt_req;
    logic i_wake;
    logic i_int_mask;
    logic o_core_clk_en;
    logic o_clock_out_select;
    logic o_tick_req;
    logic o_irq;
    power_state_t o_power_state;
    int n_errors = 0; // Mismatches
    int num_checks = 0; // Comparisons made
    int cyc = 0; // Free cycle count, also the hang guard
    int per[4] = '{8, 12, 16, 20}; // Shrunk time-base periods

    clock_prescaler_tick_timer #(.PERIOD_0(8), .PERIOD_1(12), .PERIOD_2(16), .PERIOD_3(20)) dut_u (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_halt_req(i_halt_req),
        .i_wake(i_wake), .i_int_mask(i_int_mask), .o_core_clk_en(o_core_clk_en),
        .o_clock_out_select(o_clock_out_select), .o_tick_req(o_tick_req), .o_irq(o_irq),
        .o_power_state(o_power_state)
    );

    // Clock generator, half period 5 ns
    initial i_core_clk = 1'b0;
    always #5 i_core_clk = ~i_core_clk;

    // Cycle counter; a hang is cut short well past the expected run length
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end

    // Compare with case equality so unknowns never match
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    // Let n edges pass, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask : tick

    // One-cycle register write
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        #1;
    endtask : wr

    // One-cycle register read; data is sampled in the following cycle only
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask : rd

    // Wait for the tick request to fall and rise again; returns the cycle of the rise
    task automatic wait_rise(output int t);
        int n;
        n = 0;
        while (o_tick_req === 1'b1 && n < 50) begin
            tick(1);
            n++;
        end
        while (o_tick_req !== 1'b1 && n < 300) begin
            tick(1);
            n++;
        end
        chk("tick_req_rise", 1, o_tick_req);
        t = cyc;
    endtask : wait_rise

    // Reset image, write-only word read, outputs after release
    task automatic t_reset;
        logic [7:0] d;
        chk("core_clk_en_after_reset", 1, o_core_clk_en);
        chk("clock_out_after_reset", 0, o_clock_out_select);
        rd(`CCS_ADDR_CTRL, d);
        chk("ctrl_reset", 8'h00, d);
        rd(`CCS_ADDR_IRQ_CLEAR, d);
        chk("write_only_read", 8'h00, d);
        $display("test reset done");
    endtask : t_reset

    // Tick spacing for every code; a new code waits for the running period
    task automatic t_periods;
        int t0;
        int t1;
        int t2;
        logic [7:0] d;
        wr(`CCS_ADDR_CTRL, 8'h02);
        wait_rise(t0);
        rd(`CCS_ADDR_CTRL, d);
        chk("flag_set", 1, d[0]);
        rd(`CCS_ADDR_CTRL, d);
        chk("flag_read_clear", 0, d[0]);
        for (int k = 1; k < 4; k++) begin
            // Whole-byte write; a read-modify-write would clear the flag
            wr(`CCS_ADDR_CTRL, 8'(k << 2) | 8'h02);
            wait_rise(t1);
            chk("old_period", per[k - 1], t1 - t0);
            rd(`CCS_ADDR_CTRL, d);
            wait_rise(t2);
            chk("new_period", per[k], t2 - t1);
            rd(`CCS_ADDR_CTRL, d);
            t0 = t2;
        end
        // Software cannot set the flag; other fields read back
        wr(`CCS_ADDR_CTRL, 8'h0f);
        rd(`CCS_ADDR_CTRL, d);
        chk("ctrl_readback", 8'h0e, d);
        $display("test periods done");
    endtask : t_periods

    // Sticky status, enable mask, clear, processor mask on the tick request
    task automatic t_irq;
        int n;
        logic [7:0] d;
        wr(`CCS_ADDR_IRQ_ENABLE, 8'h01);
        n = 0;
        while (o_irq !== 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
        chk("irq_raised", 1, o_irq);
        // Status is sticky from earlier ticks; the flag was read clear, so wait for the next tick
        wait_rise(n);
        chk("tick_req_unmasked", 1, o_tick_req);
        @(posedge i_core_clk);
        i_int_mask <= 1'b1;
        tick(2);
        chk("tick_req_masked", 0, o_tick_req);
        @(posedge i_core_clk);
        i_int_mask <= 1'b0;
        wr(`CCS_ADDR_IRQ_ENABLE, 8'h00);
        tick(1);
        chk("irq_disabled", 0, o_irq);
        wr(`CCS_ADDR_IRQ_ENABLE, 8'h01);
        tick(1);
        chk("irq_sticky", 1, o_irq);
        rd(`CCS_ADDR_IRQ_STATUS, d);
        chk("status_tick", 8'h01, d);
        wr(`CCS_ADDR_IRQ_CLEAR, 8'h01);
        tick(1);
        chk("irq_cleared", 0, o_irq);
        wr(`CCS_ADDR_IRQ_ENABLE, 8'h00);
        $display("test irq done");
    endtask : t_irq

    // Clock-out select and core clock enable rate for every divider code
    task automatic t_clock;
        int n;
        wr(`CCS_ADDR_CTRL, 8'h80);
        tick(2);
        chk("clock_out_on", 1, o_clock_out_select);
        wr(`CCS_ADDR_CTRL, 8'h00);
        tick(2);
        chk("clock_out_off", 0, o_clock_out_select);
        // Last pass leaves slow mode off with divider 11, which must be ignored
        for (int k = 0; k < 5; k++) begin
            wr(`CCS_ADDR_CTRL, (k < 4) ? (8'(k << 5) | 8'h10) : 8'h60);
            tick(4);
            n = 0;
            repeat (64) begin
                tick(1);
                if (o_core_clk_en === 1'b1) n++;
            end
            chk("core_clk_pulses", (k < 4) ? (64 >> (k + 1)) : 64, n);
        end
        $display("test clock done");
    endtask : t_clock

    // Halt with enable set goes to active halt and the tick wakes it
    task automatic t_halt;
        int n;
        logic [7:0] d;
        wr(`CCS_ADDR_CTRL, 8'h8e);
        @(posedge i_core_clk);
        i_halt_req <= 1'b1;
        @(posedge i_core_clk);
        i_halt_req <= 1'b0;
        tick(2);
        chk("active_halt", ST_ACTIVE_HALT, o_power_state);
        chk("clock_out_in_active_halt", 0, o_clock_out_select);
        chk("core_clk_in_halt", 0, o_core_clk_en);
        n = 0;
        while (o_power_state === ST_ACTIVE_HALT && n < 60) begin
            tick(1);
            n++;
        end
        chk("tick_wakes", ST_RUN, o_power_state);
        rd(`CCS_ADDR_IRQ_STATUS, d);
        chk("wake_status", 1, d[1]);
        // Full halt: tick must not wake, bus writes must not land
        wr(`CCS_ADDR_CTRL, 8'h8c);
        @(posedge i_core_clk);
        i_halt_req <= 1'b1;
        @(posedge i_core_clk);
        i_halt_req <= 1'b0;
        tick(2);
        chk("full_halt", ST_FULL_HALT, o_power_state);
        wr(`CCS_ADDR_CTRL, 8'h00);
        tick(60);
        chk("full_halt_holds", ST_FULL_HALT, o_power_state);
        @(posedge i_core_clk);
        i_wake <= 1'b1;
        @(posedge i_core_clk);
        i_wake <= 1'b0;
        tick(2);
        chk("wake_exit", ST_RUN, o_power_state);
        rd(`CCS_ADDR_CTRL, d);
        chk("ctrl_frozen", 8'h8c, d & 8'hfe);
        $display("test halt done");
    endtask : t_halt

    // Print the counts and the verdict, then stop
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    // Main sequence: reset for five cycles, then each scenario in turn
    initial begin
        i_rst_b = 1'b0;
        i_clk_en = 1'b1;
        i_addr = 2'h0;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_halt_req = 1'b0;
        i_wake = 1'b0;
        i_int_mask = 1'b0;
        repeat (5) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        tick(2);
        t_reset();
        t_periods();
        t_irq();
        t_clock();
        t_halt();
        summarize();
    end
endmodule : clock_prescaler_tick_timer_tb_top
